/* File: core/bas_map.vh */
// constants for the bus address select block
`ifndef BAS_MAP_VH
`define BAS_MAP_VH
`define BAS_ADDR_W        5
`define BAS_ADDR_MAX      5'h1E
`define BAS_ADDR_DEFAULT  5'h13
`define BAS_DIGIT_W       4
`define BAS_DIGIT_MAX     4'h9
`define BAS_ENTRY_W       7
`define BAS_TEN           7'h0A
`define BAS_ZERO_ADDR     5'h00
`define BAS_ZERO_ENTRY    7'h00
`define BAS_ZERO_CNT      2'h0
`define BAS_ONE_CNT       2'h1
`define BAS_MAX_DIGITS    2'h2
`endif

/* File: core/bas_entry.v */
// decimal keypad accumulator for a new bus address
`timescale 1ns/1ps
`include "bas_map.vh"
module bas_entry
#(
   parameter W = `BAS_ENTRY_W
)
(
   input  wire         clk,
   input  wire         sys_rst,
   input  wire         clear,
   input  wire         digit_stb,
   input  wire [3:0]   digit_val,
   output reg  [W-1:0] value,
   output reg  [1:0]   count
);

// -----------------------------------------------------------
// accumulate digits, value = value*10 + digit
// -----------------------------------------------------------
wire [W-1:0] next_value;
assign next_value = (value * `BAS_TEN) + {{(W-4){1'h0}}, digit_val};

// digits beyond two are ignored, result stays bounded
always @(posedge clk or posedge sys_rst)
begin
   if (sys_rst)
   begin
      value <= `BAS_ZERO_ENTRY;
      count <= `BAS_ZERO_CNT;
   end
   else if (clear)
   begin
      value <= `BAS_ZERO_ENTRY;
      count <= `BAS_ZERO_CNT;
   end
   else if (digit_stb && digit_val <= `BAS_DIGIT_MAX && count != `BAS_MAX_DIGITS)
   begin
      value <= next_value;
      count <= count + `BAS_ONE_CNT;
   end
end

endmodule

/* File: core/bas_addr_select.v */
// bus address select: switch sampling, front-panel query and entry
// Behaviour
// - address is five bits, one per segment
// - lowest segment is address lsb
// - valid codes are zero through thirty
// - switches ship holding nineteen, binary 10011
// - standard build samples switches at power-on only
// - address holds until power cycle or entry
// - query key sequence shows address on display
// - entry ended by terminator loads and shows address
// - standard build: entered address lost at power-off
// - preset leaves active address unchanged
// - battery build keeps address, ignores switches
// - stored address valid only while battery holds, except during entry until the terminator
// - no preset source alters active address
`timescale 1ns/1ps
`include "bas_map.vh"
module bas_addr_select
#(
   parameter AW = `BAS_ADDR_W
)
(
   input  wire          clk,
   input  wire          sys_rst,
   input  wire [AW-1:0] address_switch_bank,
   input  wire          battery_option,
   input  wire          battery_ok,
   input  wire [AW-1:0] retained_addr,
   input  wire          address_query_keyseq,
   input  wire          digit_stb,
   input  wire [3:0]    digit_val,
   input  wire          entry_terminator_key,
   input  wire          preset_key,
   input  wire          preset_bus_command,
   output reg  [AW-1:0] bus_addr,
   output reg           addr_valid,
   output reg           display_en,
   output reg  [AW-1:0] display_value,
   output reg           retain_we,
   output reg  [AW-1:0] retain_data,
   output reg           entry_rejected,
   output reg           preset_done
);

// -----------------------------------------------------------
// states
// -----------------------------------------------------------
localparam ST_BOOT  = 2'h0;
localparam ST_IDLE  = 2'h1;
localparam ST_ENTRY = 2'h2;

reg  [1:0]               state;
reg  [1:0]               next_state;
wire [`BAS_ENTRY_W-1:0]  entry_value;
wire [1:0]               entry_count;
wire                     entry_clear;
wire                     entry_ok;
wire [AW-1:0]            switch_addr;
wire [AW-1:0]            boot_addr;
wire                     digit_legal;
wire                     entry_digit;
genvar                   g;

// -----------------------------------------------------------
// switch segments, one address bit each
// -----------------------------------------------------------
generate
   for (g = 0; g < AW; g = g + 1)
   begin : g_seg
      // segment g feeds bit g, lowest segment is the lsb
      assign switch_addr[g] = address_switch_bank[g];
   end
endgenerate

// power-on source: battery store, or the switches otherwise
assign boot_addr = battery_option ? retained_addr : switch_addr;

// codes above nine on the keypad lines are not digits
assign digit_legal = (digit_val <= `BAS_DIGIT_MAX);
assign entry_digit = digit_stb && digit_legal && (state == ST_ENTRY);

// -----------------------------------------------------------
// keypad accumulator
// -----------------------------------------------------------
assign entry_clear = (state != ST_ENTRY);

bas_entry #(.W(`BAS_ENTRY_W)) u_entry
(
   .clk       (clk),
   .sys_rst   (sys_rst),
   .clear     (entry_clear),
   .digit_stb (entry_digit),
   .digit_val (digit_val),
   .value     (entry_value),
   .count     (entry_count)
);

// range check of the keyed value
assign entry_ok = (entry_count != `BAS_ZERO_CNT) &&
                  (entry_value <= {2'h0, `BAS_ADDR_MAX});

// -----------------------------------------------------------
// state sequencing
// -----------------------------------------------------------
always @*
begin
   next_state = state;
   case (state)
      ST_BOOT:  next_state = ST_IDLE;
      ST_IDLE:  if (address_query_keyseq) next_state = ST_ENTRY;
      ST_ENTRY: if (entry_terminator_key) next_state = ST_IDLE;
      default:  next_state = ST_BOOT;
   endcase
end

// -----------------------------------------------------------
// preset acknowledge
// -----------------------------------------------------------
// every preset source lands here and nowhere else, so no
// preset of any kind can disturb the active address
always @(posedge clk or posedge sys_rst)
begin
   if (sys_rst)
   begin
      preset_done <= 1'h0;
   end
   else
   begin
      preset_done <= preset_key | preset_bus_command;
   end
end

// -----------------------------------------------------------
// address register, display and retention
// -----------------------------------------------------------
// switches are read in the boot state only; afterwards the
// address moves solely on an accepted keypad entry
always @(posedge clk or posedge sys_rst)
begin
   if (sys_rst)
   begin
      state          <= ST_BOOT;
      bus_addr       <= `BAS_ADDR_DEFAULT;
      addr_valid     <= 1'h0;
      display_en     <= 1'h0;
      display_value  <= `BAS_ZERO_ADDR;
      retain_we      <= 1'h0;
      retain_data    <= `BAS_ZERO_ADDR;
      entry_rejected <= 1'h0;
   end
   else
   begin
      state          <= next_state;
      retain_we      <= 1'h0;
      entry_rejected <= 1'h0;
      case (state)
         ST_BOOT:
         begin
            // one-time load after power-on release
            bus_addr <= boot_addr;
            if (battery_option)
            begin
               addr_valid <= battery_ok;
            end
            else
            begin
               addr_valid <= 1'h1;
            end
         end
         ST_IDLE:
         begin
            if (address_query_keyseq)
            begin
               display_en    <= 1'h1;
               display_value <= bus_addr;
            end
            if (battery_option && !battery_ok)
            begin
               addr_valid <= 1'h0;
            end
         end
         ST_ENTRY:
         begin
            // echo each accepted digit as it is keyed
            if (entry_digit)
            begin
               display_value <= next_disp(entry_value, digit_val, entry_count);
            end
            if (entry_terminator_key)
            begin
               if (entry_ok)
               begin
                  bus_addr      <= entry_value[AW-1:0];
                  display_value <= entry_value[AW-1:0];
                  // a weak battery still leaves the store untrusted
                  addr_valid    <= battery_ok | ~battery_option;
                  retain_we     <= battery_option;
                  retain_data   <= entry_value[AW-1:0];
               end
               else
               begin
                  display_value  <= bus_addr;
                  entry_rejected <= 1'h1;
               end
            end
         end
         default:
         begin
            display_en <= 1'h0;
         end
      endcase
   end
end

// echo of the value being keyed, low bits only; a third digit
// is dropped by the accumulator, so the echo holds as well
function [AW-1:0] next_disp;
   input [`BAS_ENTRY_W-1:0] v;
   input [3:0]              d;
   input [1:0]              c;
   reg   [`BAS_ENTRY_W-1:0] t;
   begin
      t = (c == `BAS_MAX_DIGITS) ? v : (v * `BAS_TEN) + {3'h0, d};
      next_disp = t[AW-1:0];
   end
endfunction

endmodule

/* File: testbench/bas_ctrl_model.sv */
// bus controller model addressing the device
`timescale 1ns/1ps
module bas_ctrl_model
(
   input  wire [4:0] bus_addr,
   input  wire [4:0] target,
   output wire       heard
);
   // only codes 0 to 30 are used
   assign heard = (bus_addr == target) && (target <= 5'h1E);
endmodule

/* File: testbench/bas_addr_select_sva.sv */
// checker for bus address select
`timescale 1ns/1ps
module bas_chk
(
   input wire       clk,
   input wire       sys_rst,
   input wire [4:0] address_switch_bank,
   input wire       battery_option,
   input wire       battery_ok,
   input wire [4:0] retained_addr,
   input wire       address_query_keyseq,
   input wire       entry_terminator_key,
   input wire       preset_key,
   input wire       preset_bus_command,
   input wire [4:0] bus_addr,
   input wire       addr_valid,
   input wire       display_en,
   input wire [4:0] display_value,
   input wire       retain_we,
   input wire [4:0] retain_data,
   input wire       entry_rejected,
   input wire       preset_done
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   AST_RST: assert property (disable iff (1'b0) sys_rst |-> bus_addr == 5'h13) else $error("rst");
   AST_BOOT: assert property ($fell(sys_rst) |=> bus_addr == (battery_option ? retained_addr :
      address_switch_bank)) else $error("boot");
   AST_HOLD: assert property (!entry_terminator_key && !$fell(sys_rst) |=> $stable(bus_addr))
      else $error("hold");
   AST_PRESET: assert property ((preset_key || preset_bus_command) && !entry_terminator_key
      |=> preset_done && $stable(bus_addr)) else $error("preset");
   AST_QUERY: assert property (address_query_keyseq && !display_en |=> display_en &&
      display_value == $past(bus_addr)) else $error("query");
   AST_REJ: assert property (entry_rejected |-> $stable(bus_addr)) else $error("rej");
   AST_RETAIN: assert property (retain_we |-> battery_option && retain_data == bus_addr &&
      bus_addr <= 5'h1E) else $error("retain");
   AST_VALID: assert property (battery_option && !battery_ok |=> !addr_valid) else $error("valid");
   cover property (entry_rejected);
   cover property (retain_we);
   cover property (preset_done);
endmodule
bind bas_addr_select bas_chk u_chk (.*);

/* File: testbench/bas_addr_select_tb_top.sv */
// bench for bus address select
`timescale 1ns/1ps
module bas_addr_select_tb_top;
   reg        clk = 1'b0, sys_rst = 1'b0, battery_option = 1'b0, battery_ok = 1'b1;
   reg        address_query_keyseq = 1'b0, digit_stb = 1'b0, entry_terminator_key = 1'b0;
   reg        preset_key = 1'b0, preset_bus_command = 1'b0;
   reg  [4:0] address_switch_bank = 5'h13, retained_addr = 5'h0A, target = 5'h13;
   reg  [3:0] digit_val = 4'h0;
   wire [4:0] bus_addr, display_value, retain_data;
   wire       addr_valid, display_en, retain_we, entry_rejected, preset_done, heard;
   integer    miscompares = 0, n_tests = 0, i, k;
   // tens, units, digit count, address, reject
   reg [15:0] rows [0:4] = '{16'h30BC, 16'h31BD, 16'h704E, 16'h000F, 16'h0080};
   bas_addr_select DUT (.*);
   bas_ctrl_model ctrl (.*);
   always #2.5 clk = ~clk;
   task chk(input [4:0] g, input [4:0] e);
      n_tests = n_tests + 1;
      if (g !== e)
      begin
         miscompares = miscompares + 1;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // query, up to two digits, terminator
   task ent(input [3:0] t, input [3:0] u, input [1:0] n);
      @(negedge clk) address_query_keyseq = 1'b1;
      @(negedge clk) address_query_keyseq = 1'b0;
      for (k = 0; k < 2; k = k + 1)
      begin
         digit_stb = (n > k);
         digit_val = k ? u : t;
         @(negedge clk);
      end
      digit_stb = 1'b0;
      entry_terminator_key = 1'b1;
      @(negedge clk) entry_terminator_key = 1'b0;
   endtask
   task pwr;
      @(negedge clk) sys_rst = 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk) chk(bus_addr, 5'h13);
      sys_rst = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      #3000 miscompares = miscompares + 1;
      conclude;
   end
   initial
   begin
      pwr;
      chk(bus_addr, 5'h13);
      for (i = 0; i < 5; i = i + 1)
      begin
         ent(rows[i][15:12], rows[i][11:8], rows[i][7:6]);
         chk({4'h0, display_en}, 5'h01);
         chk({4'h0, retain_we}, 5'h00);
         chk({4'h0, addr_valid}, 5'h01);
         chk({4'h0, entry_rejected}, {4'h0, rows[i][0]});
         chk(bus_addr, rows[i][5:1]);
         chk(display_value, rows[i][5:1]);
         target = rows[i][5:1];
         #1 chk({4'h0, heard}, 5'h01);
         $display("row %0d done", i);
      end
      // presets and a live switch change keep the address
      @(negedge clk);
      preset_key = 1'b1;
      address_switch_bank = 5'h05;
      @(negedge clk) preset_key = 1'b0;
      preset_bus_command = 1'b1;
      chk({4'h0, preset_done}, 5'h01);
      @(negedge clk) preset_bus_command = 1'b0;
      chk({4'h0, preset_done}, 5'h01);
      chk(bus_addr, 5'h00);
      pwr;
      chk(bus_addr, 5'h05);
      // battery build ignores the switches
      battery_option = 1'b1;
      address_switch_bank = 5'h15;
      pwr;
      chk(bus_addr, 5'h0A);
      chk({4'h0, addr_valid}, 5'h01);
      ent(4'h2, 4'h5, 2'h2);
      chk({4'h0, retain_we}, 5'h01);
      chk(retain_data, 5'h19);
      battery_ok = 1'b0;
      @(negedge clk) chk({4'h0, addr_valid}, 5'h00);
      $display("hand tests done");
      conclude;
   end
endmodule
